// *** shared/host_io_decode_pkg.sv ***
// shared constants for the host i/o decode bridge
package host_io_decode_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // host i/o window
   localparam logic [9:0] DEFAULT_BASE      = 10'h300;
   localparam int         WINDOW_SEL_LSB    = 5;      // base step is 32 bytes
   localparam logic [2:0] WINDOW_FIXED_BITS = 3'h6;   // host address bits 9..7 of every base
   localparam int         WINDOW_FIXED_LSB  = 7;
   localparam int         REGION_LSB        = 3;      // 8-byte regions inside the window
   localparam int         HOST_ADDR_W       = 10;
   localparam int         HOST_DATA_W       = 16;
   localparam int         REG_DATA_W        = 8;
   localparam int         REG_ADDR_W        = 4;

   // region codes from host address bits 4..3
   localparam logic [1:0] REGION_REG_LO     = 2'h0;
   localparam logic [1:0] REGION_REG_HI     = 2'h1;
   localparam logic [1:0] REGION_DATA_PORT  = 2'h2;
   localparam logic [1:0] REGION_RESET_PORT = 2'h3;

   ////////////////////////////////////////////////////////////////////////////////
   // controller local memory space
   localparam int         LOCAL_ADDR_W      = 14;
   localparam int         LOCAL_DATA_W      = 16;
   localparam int         RAM_ADDR_W        = 13;     // 8K words
   localparam int         RAM_SELECT_BIT    = 13;     // set: buffer ram, clear: id prom
   localparam int         PROM_INDEX_W      = 5;      // 32 x 8

   // id prom layout
   localparam logic [4:0] PROM_ADDR_FIRST   = 5'h00;
   localparam logic [4:0] PROM_ADDR_LAST    = 5'h05;
   localparam logic [4:0] PROM_ZERO_FIRST   = 5'h06;
   localparam logic [4:0] PROM_ZERO_LAST    = 5'h0D;
   localparam logic [4:0] PROM_ID_A_FIRST   = 5'h0E;
   localparam logic [4:0] PROM_ID_A_LAST    = 5'h0F;
   localparam logic [4:0] PROM_COPY_FIRST   = 5'h10;
   localparam logic [4:0] PROM_COPY_LAST    = 5'h15;
   localparam logic [4:0] PROM_RSVD_FIRST   = 5'h16;
   localparam logic [4:0] PROM_RSVD_LAST    = 5'h1D;
   localparam logic [4:0] PROM_ID_B_FIRST   = 5'h1E;
   localparam logic [7:0] PROM_FILL_BYTE    = 8'h00;
   localparam logic [7:0] PROM_RSVD_BYTE    = 8'hFF;

   // host cycle tracking
   typedef enum logic [2:0] {
      CYCLE_IDLE,
      CYCLE_REG,
      CYCLE_PORT_READ,
      CYCLE_PORT_WRITE,
      CYCLE_RESET
   } cycle_state_t;

endpackage : host_io_decode_pkg

// *** rtl/station_id_prom.sv ***
// station address and identification prom, 32 x 8
`timescale 1ns/100ps
module station_id_prom
   import host_io_decode_pkg::*;
#(
   parameter logic [47:0] STATION_ADDR = 48'h02_00_00_00_00_01, // arbitrary value
   parameter logic [7:0]  ID_BYTE_A    = 8'hA5,                 // arbitrary value
   parameter logic [7:0]  ID_BYTE_B    = 8'h3C                  // arbitrary value
)(
   // lookup
   input  wire logic [PROM_INDEX_W-1:0] index,
   output logic      [7:0]              byte_out
);

   // most significant address byte sits at the lowest location
   function automatic logic [7:0] addr_byte(input logic [2:0] n);
      addr_byte = STATION_ADDR[8'(47 - 8 * int'(n)) -: 8];
   endfunction : addr_byte

   always_comb begin
      if (index <= PROM_ADDR_LAST) begin
         byte_out = addr_byte(index[2:0]);
      end else if (index <= PROM_ZERO_LAST) begin
         byte_out = PROM_FILL_BYTE;
      end else if (index <= PROM_ID_A_LAST) begin
         byte_out = ID_BYTE_A;
      end else if (index <= PROM_COPY_LAST) begin
         byte_out = addr_byte(3'(index - PROM_COPY_FIRST));
      end else if (index <= PROM_RSVD_LAST) begin
         byte_out = PROM_RSVD_BYTE;
      end else begin
         byte_out = ID_BYTE_B;
      end
   end

endmodule : station_id_prom

// *** rtl/host_io_decode_bridge.sv ***
// host i/o window decode, register transceiver, data port latches and local memory
`timescale 1ns/100ps
//
// Operation
// - claim one 32-byte host i/o block
// - first 16 bytes select controller registers
// - next 8 bytes select 16-bit data port
// - last 8 bytes select board reset
// - two jumpers pick one of four bases
// - local space holds only ram and prom
// - prom: address, zeros, second address copy
// - prom id byte pairs, reserved gap
// - four low address lines reach controller
// - register data eight bits via transceiver
// - four one-way byte latches form port
// - prom leaves via port, low byte valid
// - ram 13-bit address, 16-bit data, controller only
// - seven address lines plus strobes decode
// - packets pass port, ram, controller
// - host never reaches board memory directly
// - port read before request stalls ready
// - port read gives read ack, drives host
// - port write ack latches host data
module host_io_decode_bridge
   import host_io_decode_pkg::*;
#(
   parameter logic [47:0] STATION_ADDR = 48'h02_00_00_00_00_01, // arbitrary value
   parameter int          RAM_AW       = RAM_ADDR_W
)(
   // clock and reset
   input  wire logic                    ref_clk,
   input  wire logic                    resetn,
   // host bus pins
   input  wire logic [HOST_ADDR_W-1:0]  host_addr,
   input  wire logic                    host_io_read_n,
   input  wire logic                    host_io_write_n,
   input  wire logic [HOST_DATA_W-1:0]  host_data_in,
   output logic      [HOST_DATA_W-1:0]  host_data_out,
   output logic                         host_data_oe,
   output logic                         host_io_ready,
   // jumpers
   input  wire logic                    base_select_hi,
   input  wire logic                    base_select_lo,
   // controller slave side
   output logic                         ctrl_cs_n,
   output logic      [REG_ADDR_W-1:0]   ctrl_addr,
   output logic                         ctrl_read_n,
   output logic                         ctrl_write_n,
   input  wire logic                    controller_slave_ack,
   input  wire logic [REG_DATA_W-1:0]   ctrl_reg_data_in,
   output logic      [REG_DATA_W-1:0]   ctrl_reg_data_out,
   output logic                         ctrl_reg_data_oe,
   output logic                         ctrl_reset,
   // controller data port handshake
   input  wire logic                    port_request,
   output logic                         port_read_ack_n,
   output logic                         port_write_ack_n,
   input  wire logic                    port_fill_strobe,
   input  wire logic                    port_drain_strobe,
   // controller local memory bus
   input  wire logic [LOCAL_ADDR_W-1:0] local_addr,
   input  wire logic [LOCAL_DATA_W-1:0] local_data_from_ctrl,
   input  wire logic                    local_mem_read_strobe,
   input  wire logic                    local_mem_write_strobe,
   output logic      [LOCAL_DATA_W-1:0] local_data_to_ctrl,
   output logic                         local_data_oe,
   output logic                         ram_select,
   output logic                         prom_select
);

   if (RAM_AW + 1 != LOCAL_ADDR_W) begin : g_check
      $error("buffer ram address width must be one less than the local address width");
   end

   ////////////////////////////////////////////////////////////////////////////////
   // pin synchronisers
   logic [HOST_ADDR_W-1:0] addr_s1, addr_s2;
   logic [HOST_DATA_W-1:0] data_s1, data_s2;
   logic                   rd_s1, rd_s2, wr_s1, wr_s2;
   logic [1:0]             jp_s1, jp_s2;

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         addr_s1 <= '0;
         addr_s2 <= '0;
         data_s1 <= '0;
         data_s2 <= '0;
         rd_s1   <= 1'b1;
         rd_s2   <= 1'b1;
         wr_s1   <= 1'b1;
         wr_s2   <= 1'b1;
         jp_s1   <= 2'h0;
         jp_s2   <= 2'h0;
      end else begin
         addr_s1 <= host_addr;
         addr_s2 <= addr_s1;
         data_s1 <= host_data_in;
         data_s2 <= data_s1;
         rd_s1   <= host_io_read_n;
         rd_s2   <= rd_s1;
         wr_s1   <= host_io_write_n;
         wr_s2   <= wr_s1;
         jp_s1   <= {base_select_hi, base_select_lo};
         jp_s2   <= jp_s1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // window decode
   // only address bits 9..3 take part; bits 2..0 never change the decision
   function automatic logic window_hit(input logic [HOST_ADDR_W-1:0] a, input logic [1:0] sel);
      window_hit = (a[HOST_ADDR_W-1:WINDOW_FIXED_LSB] == WINDOW_FIXED_BITS)
                && (a[WINDOW_FIXED_LSB-1:WINDOW_SEL_LSB] == sel);
   endfunction : window_hit

   logic       hit;
   logic [1:0] region;
   logic       rd_act, wr_act;

   assign hit    = window_hit(addr_s2, jp_s2);
   assign region = addr_s2[REGION_LSB+1:REGION_LSB];
   assign rd_act = !rd_s2;
   assign wr_act = !wr_s2;

   ////////////////////////////////////////////////////////////////////////////////
   // host cycle state and host-facing outputs
   cycle_state_t           state, next_state;
   logic                   next_cs_n, next_rd_n, next_wr_n, next_reg_oe, next_reset;
   logic [REG_ADDR_W-1:0]  next_ctrl_addr;
   logic [REG_DATA_W-1:0]  next_reg_out;
   logic                   next_host_oe, next_ready, next_port_read_ack_n, next_port_write_ack_n;
   logic [HOST_DATA_W-1:0] next_host_out;
   logic [HOST_DATA_W-1:0] board_latch, next_board_latch;   // host toward board memory
   logic [HOST_DATA_W-1:0] host_latch;                      // board memory toward host

   always_comb begin
      next_state = state;
      case (state)
         CYCLE_IDLE: begin
            if (hit && (rd_act || wr_act)) begin
               case (region)
                  REGION_REG_LO, REGION_REG_HI: next_state = CYCLE_REG;
                  REGION_DATA_PORT: next_state = rd_act ? CYCLE_PORT_READ : CYCLE_PORT_WRITE;
                  default: next_state = CYCLE_RESET;
               endcase
            end
         end
         CYCLE_REG, CYCLE_PORT_READ, CYCLE_PORT_WRITE, CYCLE_RESET: begin
            if (!rd_act && !wr_act) begin
               next_state = CYCLE_IDLE;
            end
         end
         default: next_state = CYCLE_IDLE;
      endcase

      // nothing below asserts unless the window matched on entry
      next_cs_n      = (next_state != CYCLE_REG);
      next_ctrl_addr = addr_s2[REG_ADDR_W-1:0];
      next_rd_n      = !(next_state == CYCLE_REG && rd_act);
      next_wr_n      = !(next_state == CYCLE_REG && wr_act);
      next_reg_oe    = (next_state == CYCLE_REG) && wr_act;
      next_reg_out   = data_s2[REG_DATA_W-1:0];
      next_reset     = (next_state == CYCLE_RESET);
      next_port_read_ack_n    = !(next_state == CYCLE_PORT_READ && port_request);
      next_port_write_ack_n    = !(next_state == CYCLE_PORT_WRITE);
      next_host_oe   = (next_state == CYCLE_REG && rd_act) || (next_state == CYCLE_PORT_READ);
      if (next_state == CYCLE_PORT_READ) begin
         next_host_out = host_latch;
      end else begin
         next_host_out = {{(HOST_DATA_W-REG_DATA_W){1'b0}}, ctrl_reg_data_in};
      end
      // ready falls until the controller answers or fills the port
      next_ready = !((next_state == CYCLE_REG && rd_act && !controller_slave_ack)
                  || (next_state == CYCLE_PORT_READ && !port_request));
      // 374-style: the word is taken at the end of the write strobe
      next_board_latch = board_latch;
      if (state == CYCLE_PORT_WRITE && next_state != CYCLE_PORT_WRITE) begin
         next_board_latch = data_s2;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         state             <= CYCLE_IDLE;
         ctrl_cs_n         <= 1'b1;
         ctrl_addr         <= '0;
         ctrl_read_n       <= 1'b1;
         ctrl_write_n      <= 1'b1;
         ctrl_reg_data_oe  <= 1'b0;
         ctrl_reg_data_out <= '0;
         ctrl_reset        <= 1'b0;
         port_read_ack_n   <= 1'b1;
         port_write_ack_n  <= 1'b1;
         host_data_oe      <= 1'b0;
         host_data_out     <= '0;
         host_io_ready     <= 1'b1;
         board_latch       <= '0;
      end else begin
         state             <= next_state;
         ctrl_cs_n         <= next_cs_n;
         ctrl_addr         <= next_ctrl_addr;
         ctrl_read_n       <= next_rd_n;
         ctrl_write_n      <= next_wr_n;
         ctrl_reg_data_oe  <= next_reg_oe;
         ctrl_reg_data_out <= next_reg_out;
         ctrl_reset        <= next_reset;
         port_read_ack_n   <= next_port_read_ack_n;
         port_write_ack_n  <= next_port_write_ack_n;
         host_data_oe      <= next_host_oe;
         host_data_out     <= next_host_out;
         host_io_ready     <= next_ready;
         board_latch       <= next_board_latch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // local memory side: only the controller reaches ram and prom
   logic [LOCAL_DATA_W-1:0] buffer_ram [0:(1<<RAM_AW)-1];
   logic [7:0]              prom_byte;
   logic                    ram_hit;
   logic [LOCAL_DATA_W-1:0] next_local_data, next_host_latch, local_bus_value;
   logic                    next_local_oe, next_ram_sel, next_prom_sel;

   station_id_prom #(
      .STATION_ADDR (STATION_ADDR)
   ) u_prom (
      .index    (local_addr[PROM_INDEX_W-1:0]),
      .byte_out (prom_byte)
   );

   assign ram_hit = local_addr[RAM_SELECT_BIT];
   // what the port latches see on the local bus this cycle
   assign local_bus_value = local_data_oe ? local_data_to_ctrl : local_data_from_ctrl;

   always_comb begin
      next_ram_sel  = (local_mem_read_strobe || local_mem_write_strobe) && ram_hit;
      next_prom_sel = local_mem_read_strobe && !ram_hit;
      next_local_oe = local_mem_read_strobe || port_drain_strobe;
      if (port_drain_strobe) begin
         next_local_data = board_latch;
      end else if (ram_hit) begin
         next_local_data = buffer_ram[local_addr[RAM_AW-1:0]];
      end else begin
         next_local_data = {8'h00, prom_byte};
      end
      next_host_latch = host_latch;
      if (port_fill_strobe) begin
         next_host_latch = local_bus_value;
      end
   end

   // host data never reaches this array; only the port latches do
   always_ff @(posedge ref_clk) begin
      if (local_mem_write_strobe && ram_hit) begin
         buffer_ram[local_addr[RAM_AW-1:0]] <= local_data_from_ctrl;
      end
   end

   always_ff @(posedge ref_clk or negedge resetn) begin
      if (!resetn) begin
         local_data_to_ctrl <= '0;
         local_data_oe      <= 1'b0;
         ram_select         <= 1'b0;
         prom_select        <= 1'b0;
         host_latch         <= '0;
      end else begin
         local_data_to_ctrl <= next_local_data;
         local_data_oe      <= next_local_oe;
         ram_select         <= next_ram_sel;
         prom_select        <= next_prom_sel;
         host_latch         <= next_host_latch;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // assertions
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!resetn);

   property p_outside_quiet;
      (state == CYCLE_IDLE && !hit) |=> (ctrl_cs_n && port_read_ack_n && port_write_ack_n
                                         && !ctrl_reset && !host_data_oe);
   endproperty
   a_outside_quiet: assert property (p_outside_quiet) else $error("select outside window");

   // judged from the raw address, not through window_hit, so a broken decode shows
   property p_base_select;
      (state == CYCLE_IDLE && (rd_act || wr_act) && addr_s2[9:5] != DEFAULT_BASE[9:5] + 5'(jp_s2))
         |=> state == CYCLE_IDLE;
   endproperty
   a_base_select: assert property (p_base_select) else $error("window base mismatch");

   property p_reg_select;
      (state == CYCLE_IDLE && hit && !region[1] && (rd_act || wr_act)) |=> !ctrl_cs_n && ctrl_reset == 1'b0;
   endproperty
   a_reg_select: assert property (p_reg_select) else $error("register block not selected");

   property p_port_read;
      (state == CYCLE_IDLE && hit && region == 2'h2 && rd_act && port_request)
         |=> !port_read_ack_n && host_data_oe && ctrl_cs_n;
   endproperty
   a_port_read: assert property (p_port_read) else $error("port read not acknowledged");

   property p_port_wait;
      (next_state == CYCLE_PORT_READ && !port_request) |=> !host_io_ready && port_read_ack_n;
   endproperty
   a_port_wait: assert property (p_port_wait) else $error("no wait before port filled");

   property p_reset_port;
      (state == CYCLE_IDLE && hit && region == 2'h3 && (rd_act || wr_act)) |=> ctrl_reset ##1 (ctrl_reset || rd_s2 && wr_s2);
   endproperty
   a_reset_port: assert property (p_reset_port) else $error("reset range ignored");

   property p_write_latch;
      (state == CYCLE_PORT_WRITE && !wr_act && !rd_act) |=> board_latch == $past(data_s2) && port_write_ack_n;
   endproperty
   a_write_latch: assert property (p_write_latch) else $error("port write not latched");

   property p_strobe_needs_cs;
      (!ctrl_read_n || !ctrl_write_n || ctrl_reg_data_oe) |-> !ctrl_cs_n;
   endproperty
   a_strobe_needs_cs: assert property (p_strobe_needs_cs) else $error("strobe without select");

   property p_prom_low_byte;
      (local_mem_read_strobe && !ram_hit && !port_drain_strobe)
         |=> local_data_oe && prom_select && local_data_to_ctrl[15:8] == 8'h00;
   endproperty
   a_prom_low_byte: assert property (p_prom_low_byte) else $error("prom upper byte not clear");

   property p_ram_readback;
      (local_mem_write_strobe && ram_hit && !local_mem_read_strobe)
         ##1 (local_mem_read_strobe && $stable(local_addr) && !port_drain_strobe && !local_mem_write_strobe)
         |=> local_data_to_ctrl == $past(local_data_from_ctrl, 2);
   endproperty
   a_ram_readback: assert property (p_ram_readback) else $error("ram word lost");

   c_reg_cycle:  cover property (state == CYCLE_REG && !ctrl_read_n ##1 controller_slave_ack);
   c_port_read:  cover property (state == CYCLE_PORT_READ && !host_io_ready ##[1:20] !port_read_ack_n);
   c_port_write: cover property (!port_write_ack_n ##1 port_write_ack_n);
   c_reset:      cover property (ctrl_reset);

endmodule : host_io_decode_bridge

// *** verification/ctrl_model.sv ***
// controller-side model: slave ack, register data, local bus cycles
`timescale 1ns/100ps
module ctrl_model
   import host_io_decode_pkg::*;
(
   // clock
   input  wire logic                    ref_clk,
   // slave side
   input  wire logic [REG_ADDR_W-1:0]   ctrl_addr,
   input  wire logic                    ctrl_read_n,
   output logic                         controller_slave_ack,
   output logic      [REG_DATA_W-1:0]   ctrl_reg_data_in,
   // port and local bus
   input  wire logic [LOCAL_DATA_W-1:0] local_data_to_ctrl,
   input  wire logic                    ram_select,
   input  wire logic                    prom_select,
   output logic                         port_request,
   output logic                         port_fill_strobe,
   output logic                         port_drain_strobe,
   output logic      [LOCAL_ADDR_W-1:0] local_addr,
   output logic      [LOCAL_DATA_W-1:0] local_data_from_ctrl,
   output logic                         local_mem_read_strobe,
   output logic                         local_mem_write_strobe
);
   logic [3:0] ack_sr = 4'h0;
   // slow ack, so the host always sees wait states first
   always @(posedge ref_clk) ack_sr <= {ack_sr[2:0], ~ctrl_read_n};
   assign controller_slave_ack = ack_sr[3];
   // undriven bus shows the inverse, never the last byte
   assign ctrl_reg_data_in = ctrl_read_n ? ~{4'h5, ctrl_addr} : {4'h5, ctrl_addr};
   initial begin
      {port_request, port_fill_strobe, port_drain_strobe} = 3'h0;
      {local_mem_read_strobe, local_mem_write_strobe} = 2'h0;
      local_addr = 14'h0000;
      local_data_from_ctrl = 16'hA5A5;
   end
   task mem_cycle(input logic [13:0] a, input logic wr, input logic [15:0] d, input logic fill,
                  output logic [15:0] q, output logic [1:0] s);
      @(negedge ref_clk);
      local_addr = a;
      local_data_from_ctrl = d;
      local_mem_write_strobe = wr;
      local_mem_read_strobe = ~wr;
      @(negedge ref_clk);
      q = local_data_to_ctrl;
      s = {ram_select, prom_select};
      port_fill_strobe = fill;
      local_mem_write_strobe = 1'b0;
      local_mem_read_strobe = fill;
      @(negedge ref_clk);
      port_fill_strobe = 1'b0;
      local_mem_read_strobe = 1'b0;
      local_data_from_ctrl = ~d;
   endtask : mem_cycle
   task drain(output logic [15:0] q);
      @(negedge ref_clk);
      port_drain_strobe = 1'b1;
      @(negedge ref_clk);
      q = local_data_to_ctrl;
      port_drain_strobe = 1'b0;
   endtask : drain
endmodule : ctrl_model

// *** verification/host_io_decode_bridge_tb.sv ***
// self-checking bench for the host i/o decode bridge
`timescale 1ns/100ps
module host_io_decode_bridge_tb
   import host_io_decode_pkg::*;
;
   localparam logic [47:0] SA = 48'h0A_1B_2C_3D_4E_5F; // arbitrary value
   logic        ref_clk = 1'b0, resetn = 1'b0, base_select_hi = 1'b0, base_select_lo = 1'b0;
   logic [9:0]  host_addr = 10'h000, base;
   logic        host_io_read_n = 1'b1, host_io_write_n = 1'b1;
   logic [15:0] host_data_in = 16'h0000, host_data_out, local_data_from_ctrl, local_data_to_ctrl;
   logic        host_data_oe, host_io_ready, ctrl_cs_n, ctrl_read_n, controller_slave_ack;
   logic [3:0]  ctrl_addr;
   logic [7:0]  ctrl_reg_data_in, ctrl_reg_data_out;
   logic        ctrl_write_n, ctrl_reg_data_oe, local_data_oe;
   logic        ctrl_reset, port_request, port_read_ack_n, port_write_ack_n, port_fill_strobe;
   logic        port_drain_strobe, local_mem_read_strobe, local_mem_write_strobe, ram_select, prom_select;
   logic [13:0] local_addr;
   int          bad_count = 0, samples_checked = 0, cycles = 0;

   host_io_decode_bridge #(.STATION_ADDR(SA)) host_io_decode_bridge_inst (.ref_clk, .resetn,
      .host_addr, .host_io_read_n, .host_io_write_n, .host_data_in, .host_data_out, .host_data_oe,
      .host_io_ready, .base_select_hi, .base_select_lo, .ctrl_cs_n, .ctrl_addr, .ctrl_read_n,
      .ctrl_write_n, .controller_slave_ack, .ctrl_reg_data_in, .ctrl_reg_data_out,
      .ctrl_reg_data_oe, .ctrl_reset, .port_request, .port_read_ack_n, .port_write_ack_n,
      .port_fill_strobe, .port_drain_strobe, .local_addr, .local_data_from_ctrl,
      .local_mem_read_strobe, .local_mem_write_strobe, .local_data_to_ctrl, .local_data_oe,
      .ram_select, .prom_select);
   ctrl_model ctrl_model_inst (.ref_clk, .ctrl_addr, .ctrl_read_n, .controller_slave_ack,
      .ctrl_reg_data_in, .local_data_to_ctrl, .ram_select, .prom_select, .port_request,
      .port_fill_strobe, .port_drain_strobe, .local_addr, .local_data_from_ctrl,
      .local_mem_read_strobe, .local_mem_write_strobe);

   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [7:0] prom_exp(input int i);
      if (i < 6) return SA[47-8*i -: 8];
      if (i < 14) return 8'h00;
      if (i < 16) return 8'hA5;
      if (i < 22) return SA[47-8*(i-16) -: 8];
      if (i < 30) return 8'hFF;
      return 8'h3C;
   endfunction : prom_exp
   task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", name, exp, seen);
      end
   endtask : check
   task host_start(input logic [9:0] a, input logic wr, input logic [15:0] d);
      host_addr = a;
      host_data_in = d;
      host_io_write_n = ~wr;
      host_io_read_n = wr;
      repeat (4) @(negedge ref_clk);
   endtask : host_start
   task host_end;
      {host_io_read_n, host_io_write_n} = 2'h3;
      // data held one cycle past the strobe so the latch edge is safe
      @(negedge ref_clk);
      host_data_in = ~host_data_in;
      repeat (3) @(negedge ref_clk);
   endtask : host_end
   task wait_ready;
      for (int n = 0; n < 40 && host_io_ready !== 1'b1; n++) @(negedge ref_clk);
   endtask : wait_ready

   ////////////////////////////////////////////////////////////////////////////////
   task reg_and_window;
      for (int b = 0; b < 4; b++) begin
         {base_select_hi, base_select_lo} = 2'(b);
         base = DEFAULT_BASE + 10'(b * 32);
         repeat (3) @(negedge ref_clk);
         host_start(base + 10'(3 + 4 * b), 1'b0, 16'h0000);
         check("cs_n", 16'(ctrl_cs_n), 16'h0000);
         check("ctrl_addr", 16'(ctrl_addr), 16'(3 + 4 * b));
         check("ready", 16'(host_io_ready), 16'h0000);
         wait_ready();
         check("reg data", host_data_out, 16'(8'h50 + 3 + 4 * b));
         host_end();
         check("cs_n off", 16'(ctrl_cs_n), 16'h0001);
         host_start(base ^ 10'h020, 1'b0, 16'h0000);
         check("foreign cs_n", 16'(ctrl_cs_n), 16'h0001);
         check("foreign oe", 16'(host_data_oe), 16'h0000);
         host_end();
      end
   endtask : reg_and_window
   task port_write_reset;
      logic [15:0] q;
      host_start(base + 10'h010, 1'b1, 16'hBEEF);
      check("write ack", 16'(port_write_ack_n), 16'h0000);
      host_end();
      check("write ack off", 16'(port_write_ack_n), 16'h0001);
      ctrl_model_inst.drain(q);
      check("board latch", q, 16'hBEEF);
      check("drain oe", 16'(local_data_oe), 16'h0001);
      // upper host byte must not reach the 8-bit register path
      host_start(base + 10'h00A, 1'b1, 16'hA5C3);
      check("reg write_n", 16'(ctrl_write_n), 16'h0000);
      check("reg read_n", 16'(ctrl_read_n), 16'h0001);
      check("reg wr data", 16'(ctrl_reg_data_out), 16'h00C3);
      check("reg wr oe", 16'(ctrl_reg_data_oe), 16'h0001);
      host_end();
      host_start(base + 10'h01C, 1'b1, 16'h0000);
      check("reset on", 16'(ctrl_reset), 16'h0001);
      check("reset cs_n", 16'(ctrl_cs_n), 16'h0001);
      host_end();
      check("reset off", 16'(ctrl_reset), 16'h0000);
   endtask : port_write_reset
   task local_mem;
      logic [15:0] q;
      logic [1:0]  s;
      // fill set: the read strobe follows the write at once, same address
      ctrl_model_inst.mem_cycle(14'h2005, 1'b1, 16'h1234, 1'b1, q, s);
      ctrl_model_inst.mem_cycle(14'h2005, 1'b0, 16'h0000, 1'b0, q, s);
      check("ram word", q, 16'h1234);
      check("ram sel", 16'(s), 16'h0002);
      // a write aimed at the prom must leave it untouched
      ctrl_model_inst.mem_cycle(14'h0002, 1'b1, 16'h5555, 1'b0, q, s);
      for (int i = 0; i < 32; i++) begin
         ctrl_model_inst.mem_cycle(14'(i), 1'b0, 16'h0000, 1'b0, q, s);
         check("prom byte", q, 16'(prom_exp(i)));
         check("prom sel", 16'(s), 16'h0001);
      end
   endtask : local_mem
   task port_read;
      logic [15:0] q;
      logic [1:0]  s;
      host_start(base + 10'h012, 1'b0, 16'h0000);
      check("stall", 16'(host_io_ready), 16'h0000);
      check("early read ack", 16'(port_read_ack_n), 16'h0001);
      ctrl_model_inst.mem_cycle(14'h0001, 1'b0, 16'h0000, 1'b1, q, s);
      ctrl_model_inst.port_request = 1'b1;
      wait_ready();
      check("read ack", 16'(port_read_ack_n), 16'h0000);
      check("port data", host_data_out, 16'(prom_exp(1)));
      check("port oe", 16'(host_data_oe), 16'h0001);
      host_end();
      // port already filled on entry: no wait, ack at once
      host_start(base + 10'h014, 1'b0, 16'h0000);
      check("ready filled", 16'(host_io_ready), 16'h0001);
      check("read ack filled", 16'(port_read_ack_n), 16'h0000);
      host_end();
      ctrl_model_inst.port_request = 1'b0;
      check("port oe off", 16'(host_data_oe), 16'h0000);
   endtask : port_read

   ////////////////////////////////////////////////////////////////////////////////
   task test_done;
      $display("checked %0d, mismatches %0d", samples_checked, bad_count);
      if (bad_count == 0 && samples_checked > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask : test_done
   initial begin
      forever #2 ref_clk = ~ref_clk;
   end
   // whole run is a few hundred cycles; this only cuts a hang short
   always @(posedge ref_clk) begin
      cycles <= cycles + 1;
      if (cycles == 3000) begin
         bad_count++;
         test_done();
      end
   end
   initial begin
      repeat (20) @(negedge ref_clk);
      resetn = 1'b1;
      repeat (3) @(negedge ref_clk);
      check("idle ready", 16'(host_io_ready), 16'h0001);
      reg_and_window();
      port_write_reset();
      local_mem();
      port_read();
      test_done();
   end
endmodule : host_io_decode_bridge_tb
